// *** sgp_pin_cell.sv ***
// per-pin output driver and read-back selection for the port
module sgp_pin_cell #(
  parameter int unsigned PINS = sgp_pkg::SGP_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PINS-1:0] dir,
  input wire logic [PINS-1:0] data,
  input wire logic [PINS-1:0] pin_in,
  output sgp_pkg::sgp_pins_s pins_q,
  output logic [PINS-1:0] readback
);
  import sgp_pkg::*;

  // refuse a pin count that the packed pin word cannot carry
  if (PINS != SGP_PINS) begin : g_bad_pins
    $error("sgp_pin_cell: PINS must match SGP_PINS");
  end

  genvar g;
  for (g = 0; g < PINS; g++) begin : g_pin
    // output bit: driver shows the latch from the next edge on
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pins_q.level[g] <= 1'b0;
        pins_q.oe[g] <= 1'b0;
      end else begin
        pins_q.level[g] <= data[g];
        pins_q.oe[g] <= dir[g];
      end
    end
    // outputs read the latch, inputs read the pin
    assign readback[g] = dir[g] ? data[g] : pin_in[g];
  end

endmodule : sgp_pin_cell

// *** sgp_pin_model.sv ***
// far-side pin model: board drivers meet the port's own drivers
module sgp_pin_model (
  input wire logic [5:0] ext,
  input wire sgp_pkg::sgp_pins_s pins_q,
  output logic [5:0] pin_in
);
  // a driven pin shows the port's level, an undriven one the board's
  assign pin_in = (pins_q.oe & pins_q.level) | (~pins_q.oe & ext);
endmodule : sgp_pin_model

// *** sgp_pkg.sv ***
// package for the six-bit general-purpose port: register map, reset values, bus types
package sgp_pkg;

  localparam int unsigned SGP_PINS = 6;
  localparam int unsigned SGP_REG_W = 8;
  localparam int unsigned SGP_ADDR_W = 16;

  // printed offsets are not all multiples of four: keep them as indices, byte address is 4x
  localparam logic [SGP_ADDR_W-1:0] SGP_IDX_DIR = 16'hFFD0;
  localparam logic [SGP_ADDR_W-1:0] SGP_IDX_DATA = 16'hFFD2;
  localparam logic [SGP_ADDR_W-1:0] SGP_IDX_STANDBY = 16'hFFD4;
  localparam logic [SGP_ADDR_W+1:0] SGP_ADDR_DIR = {SGP_IDX_DIR, 2'b00};
  localparam logic [SGP_ADDR_W+1:0] SGP_ADDR_DATA = {SGP_IDX_DATA, 2'b00};
  localparam logic [SGP_ADDR_W+1:0] SGP_ADDR_STANDBY = {SGP_IDX_STANDBY, 2'b00};

  localparam logic [SGP_REG_W-1:0] SGP_DIR_RESET = 8'hC0;
  localparam logic [SGP_REG_W-1:0] SGP_DATA_RESET = 8'hC0;
  localparam logic [SGP_REG_W-1:0] SGP_RSVD_ONES = 8'hC0;
  localparam logic [SGP_REG_W-1:0] SGP_DIR_READ = 8'hFF;
  localparam int unsigned SGP_STBY_HW_BIT = 0;
  localparam int unsigned SGP_STBY_SW_BIT = 1;

  localparam logic [1:0] SGP_RESP_OKAY = 2'b00;
  localparam logic [1:0] SGP_RESP_SLVERR = 2'b10;

  // pin group carried as one word
  typedef struct packed {
    logic [SGP_PINS-1:0] level;
    logic [SGP_PINS-1:0] oe;
  } sgp_pins_s;

  typedef enum logic [1:0] {
    SGP_WR_IDLE = 2'b01,
    SGP_WR_RESP = 2'b10
  } sgp_wr_e;

endpackage : sgp_pkg

// *** sgp_port.sv ***
// six-bit general-purpose port with AXI4-Lite register access
//
// Contract
// - six bidirectional pins, shared with serial and interrupts
// - same pin functions in every operating mode
// - direction bit 1 output, 0 input
// - direction register write-only, reads all ones
// - direction resets to C0, also hardware standby
// - software standby keeps both registers
// - outputs keep driving during software standby
// - output pins read back data latch
// - input pins read back pin level
// - data bits 7..6 reserved, read one
// - data resets to C0, also hardware standby
//
// Implementation choice: the AXI4-Lite slave port.
module sgp_port #(
  parameter int unsigned PINS = sgp_pkg::SGP_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sgp_pkg::SGP_ADDR_W+1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sgp_pkg::SGP_ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [sgp_pkg::SGP_PINS-1:0] pin_in,
  output sgp_pkg::sgp_pins_s pins_q,
  output logic [sgp_pkg::SGP_PINS-1:0] dir_q
);
  import sgp_pkg::*;

  // the register map has room for six pins only, so refuse any other count
  if (PINS != SGP_PINS) begin : g_bad_pins
    $error("sgp_port: PINS must be six");
  end

  logic [SGP_REG_W-1:0] dir_reg_q;
  logic [SGP_REG_W-1:0] data_reg_q;
  logic [1:0] standby_q;
  logic hw_standby;
  logic aw_held_q;
  logic w_held_q;
  logic [SGP_ADDR_W+1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  sgp_wr_e wr_state_q;
  logic wr_fire;
  logic [PINS-1:0] readback;
  logic [SGP_REG_W-1:0] read_word;

  // standby control: hardware standby forces reset values, software standby changes nothing
  assign hw_standby = standby_q[SGP_STBY_HW_BIT];

  // write fires once both address and data are held
  assign wr_fire = aw_held_q && w_held_q && (wr_state_q == SGP_WR_IDLE);

  // address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // each ready only while its own channel holds nothing, so each channel is taken once per write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) &&
                       (wr_state_q == SGP_WR_IDLE);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) &&
                      (wr_state_q == SGP_WR_IDLE);
    end
  end

  // data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // write response machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= SGP_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SGP_RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        SGP_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= SGP_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == SGP_ADDR_DIR || awaddr_q == SGP_ADDR_DATA ||
                            awaddr_q == SGP_ADDR_STANDBY) ? SGP_RESP_OKAY : SGP_RESP_SLVERR;
          end
        end
        SGP_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= SGP_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= SGP_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // direction register, low lane only
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      dir_reg_q <= SGP_DIR_RESET;
    end else if (wr_fire && awaddr_q == SGP_ADDR_DIR && wstrb_q[0]) begin
      dir_reg_q <= wdata_q[SGP_REG_W-1:0] | SGP_RSVD_ONES;
    end
  end

  // data register; the reserved top bits stay one
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      data_reg_q <= SGP_DATA_RESET;
    end else if (wr_fire && awaddr_q == SGP_ADDR_DATA && wstrb_q[0]) begin
      data_reg_q <= wdata_q[SGP_REG_W-1:0] | SGP_RSVD_ONES;
    end
  end

  // standby control register; software standby has no effect on port state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_q <= 2'b00;
    end else if (wr_fire && awaddr_q == SGP_ADDR_STANDBY && wstrb_q[0]) begin
      standby_q <= wdata_q[1:0];
    end
  end

  // pin drivers are mode independent: one path for all operating modes
  sgp_pin_cell #(
    .PINS(PINS)
  ) u_cells (
    .aclk(aclk),
    .aresetn(aresetn),
    .dir(dir_reg_q[PINS-1:0]),
    .data(data_reg_q[PINS-1:0]),
    .pin_in(pin_in),
    .pins_q(pins_q),
    .readback(readback)
  );

  // direction exposed for the pin muxing of serial and interrupt functions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= '0;
    end else begin
      dir_q <= dir_reg_q[PINS-1:0];
    end
  end

  // read word selection
  always_comb begin
    unique case (s_axi_araddr)
      SGP_ADDR_DIR: read_word = SGP_DIR_READ;
      SGP_ADDR_DATA: read_word = SGP_RSVD_ONES | {2'b00, readback};
      SGP_ADDR_STANDBY: read_word = {6'h00, standby_q};
      default: read_word = '0;
    endcase
  end

  // read channel: one cycle to answer, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SGP_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, read_word};
      s_axi_rresp <= (s_axi_araddr == SGP_ADDR_DIR || s_axi_araddr == SGP_ADDR_DATA ||
                      s_axi_araddr == SGP_ADDR_STANDBY) ? SGP_RESP_OKAY : SGP_RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sgp_port

// *** sgp_port_properties.sv ***
// checker for the six-bit port: register reads, handshakes and pin enables
module sgp_port_properties
  import sgp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SGP_ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SGP_PINS-1:0] pin_in,
  input wire sgp_pins_s pins_q,
  input wire logic [SGP_PINS-1:0] dir_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a read taken at one address, then its answer
  sequence s_rd(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_ans(d, r);
    s_axi_rvalid && s_axi_rdata == d && s_axi_rresp == r;
  endsequence
  property p_dir_rd;
    s_rd(SGP_ADDR_DIR) |=> s_ans(32'hFF, SGP_RESP_OKAY);
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
  property p_in_rd;
    s_rd(SGP_ADDR_DATA) |=> ((s_axi_rdata[5:0] ^ $past(pin_in)) & ~$past(dir_q)) == 6'h0;
  endproperty
  a_in_rd: assert property (p_in_rd) else $error("input pin read wrong");
  property p_out_rd;
    s_rd(SGP_ADDR_DATA) |=> ((s_axi_rdata[5:0] ^ $past(pins_q.level)) & $past(dir_q)) == 6'h0;
  endproperty
  a_out_rd: assert property (p_out_rd) else $error("output pin read wrong");
  property p_rsvd;
    s_rd(SGP_ADDR_DATA) |=> s_axi_rdata[31:6] == 26'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_oe;
    // enable and direction copy are loaded from the same register on the same edge
    pins_q.oe == dir_q;
  endproperty
  a_oe: assert property (p_oe) else $error("enable not following direction");
  property p_rst;
    $rose(aresetn) |-> dir_q == SGP_DIR_RESET[5:0] && pins_q.oe == 6'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("direction not reset");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
endmodule : sgp_port_properties

bind sgp_port sgp_port_properties i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .pin_in(pin_in), .pins_q(pins_q), .dir_q(dir_q));

// *** test_six_bit_gpio_port_nine.sv ***
// testbench for the six-bit port: bus tasks, random and corner cases
module test_six_bit_gpio_port_nine;
  timeunit 1ns;
  timeprecision 1ns;
  import sgp_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic awr, wrdy, bv, arr, rv;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0, rdd;
  logic [1:0] br, rr;
  logic [5:0] ext = 6'h0, pin, dq;
  logic [3:0] ws = 4'h1;
  sgp_pins_s pq;
  int fail_count = 0, checks = 0, cyc = 0;
  integer seed = 32'h3f48;
  // 20 ns clock and a cycle limit against hangs
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  sgp_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .pin_in(pin), .pins_q(pq),
    .dir_q(dq));
  sgp_pin_model i_pins (.ext(ext), .pins_q(pq), .pin_in(pin));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bv);
    bry <= 1'h0;
    chk("bresp", 32'(e), 32'(br));
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rry <= 1'h0;
    chk("rdata", e, rdd);
    chk("rresp", 32'(er), 32'(rr));
  endtask : rd
  // outputs read their latch, inputs the board level, top two bits high
  function automatic logic [31:0] exp_dat(logic [5:0] dir, logic [5:0] dat, logic [5:0] x);
    return {24'h0, 2'h3, (dir & dat) | (~dir & x)};
  endfunction : exp_dat
  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
  endtask : do_reset
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // defaults, random settings with all-in and all-out first, refusals, standby, reset
  initial begin
    logic [7:0] w;
    logic [5:0] d, x;
    do_reset();
    x = 6'h2A;
    ext <= x;
    rd(SGP_ADDR_DIR, 32'hFF, SGP_RESP_OKAY);
    rd(SGP_ADDR_DATA, exp_dat(6'h0, 6'h0, x), SGP_RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      d = i < 2 ? {6{i[0]}} : 6'($random(seed));
      w = 8'($random(seed));
      x = 6'($random(seed));
      ext <= x;
      wr(SGP_ADDR_DIR, {2'h3, d}, SGP_RESP_OKAY);
      wr(SGP_ADDR_DATA, w, SGP_RESP_OKAY);
      rd(SGP_ADDR_DATA, exp_dat(d, w[5:0], x), SGP_RESP_OKAY);
      chk("level", 32'(d & w[5:0]), 32'(pq.level & d));
      chk("dir", 32'(d), 32'(dq));
    end
    // a write with the low lane disabled must leave the data register alone
    ws <= 4'h0;
    wr(SGP_ADDR_DATA, ~w, SGP_RESP_OKAY);
    ws <= 4'h1;
    rd(SGP_ADDR_DATA, exp_dat(d, w[5:0], x), SGP_RESP_OKAY);
    wr(18'h0, 8'h0, SGP_RESP_SLVERR);
    rd(18'h4, 32'h0, SGP_RESP_SLVERR);
    wr(SGP_ADDR_STANDBY, 8'h2, SGP_RESP_OKAY);
    x = ~x;
    ext <= x;
    rd(SGP_ADDR_DATA, exp_dat(d, w[5:0], x), SGP_RESP_OKAY);
    chk("oe", 32'(d), 32'(pq.oe));
    wr(SGP_ADDR_STANDBY, 8'h1, SGP_RESP_OKAY);
    rd(SGP_ADDR_DATA, exp_dat(6'h0, 6'h0, x), SGP_RESP_OKAY);
    wr(SGP_ADDR_STANDBY, 8'h0, SGP_RESP_OKAY);
    chk("oe", 32'h0, 32'(pq.oe));
    wr(SGP_ADDR_DIR, 8'hFF, SGP_RESP_OKAY);
    do_reset();
    rd(SGP_ADDR_DATA, exp_dat(6'h0, 6'h0, x), SGP_RESP_OKAY);
    test_done();
  end
endmodule : test_six_bit_gpio_port_nine
